/* File: rtl/amp_params.svh */
// constants for the amplifier control link, pins and fault logic
`ifndef AMP_PARAMS_SVH
`define AMP_PARAMS_SVH
`define AMP_CLK_MHZ 10
`define AMP_SCL_NS 2500
`define AMP_SCL_QTR ((`AMP_SCL_NS * `AMP_CLK_MHZ + 3999) / 4000)
`define AMP_STBY_US 1000
`define AMP_STBY_CYC (`AMP_STBY_US * `AMP_CLK_MHZ)
`define AMP_ADDR_HI 5'h1b
`define AMP_REG_STAT 2'h0
`define AMP_REG_CTRL 2'h1
`define AMP_REG_MODE 2'h2
`define AMP_REG_CLR 2'h3
`define AMP_CTRL_RST 8'h00
`define AMP_ST_OTW 4
`define AMP_ST_CLIP 5
`define AMP_ST_FOLD 6
`define AMP_CT_RUN 0
`define AMP_CT_PLAY 1
`define AMP_CT_FSW 2
`define AMP_CT_PIN 4:3
`define AMP_PIN_WARN 2'h0
`define AMP_PIN_CLIP 2'h1
`define AMP_PIN_BOTH 2'h2
`define AMP_PIN_TWEET 2'h3
`define AMP_WB_CTRL 4'h0
`define AMP_WB_XFER 4'h4
`define AMP_WB_STAT 4'h8
`define AMP_HC_MUTE 0
`define AMP_HC_STBY 1
`define AMP_XF_START 8
`define AMP_XF_STOP 9
`define AMP_XF_READ 10
`define AMP_XF_NACK 11
`define AMP_HS_BUSY 0
`define AMP_HS_ACK 1
`define AMP_HS_FAULT 2
`define AMP_HS_CLIP 3
`define AMP_HS_RX 15:8
`endif

/* File: rtl/amp_pkg.sv */
// types shared by the amplifier device end and the controller end
package amp_pkg;
    typedef enum logic [1:0] {
        mode_stby, mode_hiz, mode_mute, mode_play
    } amp_mode_t;
    typedef enum logic [2:0] {
        ds_idle, ds_addr, ds_ack, ds_rx, ds_tx, ds_rack, ds_rnext
    } amp_dstate_t;
    typedef enum logic [1:0] {
        hs_idle, hs_start, hs_bits, hs_stop
    } amp_hstate_t;
    typedef struct packed {
        amp_dstate_t st;
        logic [7:0] sh;
        logic [3:0] bits;
        logic rw;
        logic first;
        logic [7:0] ptr;
        logic scl_p;
        logic sda_p;
        logic sda_oe;
        logic [7:0] ctrl;
        logic [3:0] lat;
        amp_mode_t mode;
        logic [15:0] cnt;
        logic fault_oe;
        logic clip_oe;
        logic osc_master;
        logic hard_mute;
    } amp_dev_t;
    typedef struct packed {
        amp_hstate_t st;
        logic [3:0] q;
        logic [1:0] ph;
        logic [3:0] bits;
        logic [8:0] tx;
        logic [8:0] rx;
        logic stop;
        logic scl_oe;
        logic sda_oe;
        logic mute_n;
        logic standby_n;
        logic ack;
        logic [31:0] dat;
    } amp_host_t;
endpackage

/* File: rtl/amp_if.sv */
// two-wire bus plus discrete pins between controller and amplifier
`timescale 1ns/10ps
interface amp_if;
    logic scl_oe;
    logic sda_oe_h;
    logic sda_oe_d;
    logic fault_oe;
    logic clip_oe;
    logic mute_n;
    logic standby_n;
    logic scl;
    logic sda;
    logic fault_n;
    logic clip_n;
    // wired-and with pull-ups: any driver pulls the line low
    assign scl = ~scl_oe;
    assign sda = ~(sda_oe_h | sda_oe_d);
    assign fault_n = ~fault_oe;
    assign clip_n = ~clip_oe;
    modport dev(input scl, input sda, input mute_n, input standby_n,
        output sda_oe_d, output fault_oe, output clip_oe);
    modport host(output scl_oe, output sda_oe_h, output mute_n,
        output standby_n, input sda, input fault_n, input clip_n);
endinterface

/* File: rtl/amp_sync.sv */
// two-stage synchroniser for levels from outside the clock domain
`timescale 1ns/10ps
module amp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // raw in, synchronised out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] outv;
    } amp_sync_t;
    amp_sync_t r;
    amp_sync_t n;
    always_comb begin
        n = r;
        n.meta = d;
        n.outv = r.meta;
    end
    always_ff @(posedge clock) begin
        if (srst) begin
            r <= {INIT, INIT};
        end else begin
            r <= n;
        end
    end
    assign q = r.outv;
endmodule

/* File: rtl/amp_dev.sv */
// amplifier end: two-wire slave, control/status bytes, modes and faults
//
// Local design decisions: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
`include "amp_params.svh"
module amp_dev #(
    parameter logic [15:0] STBY_CYC = 16'(`AMP_STBY_CYC)
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // bus and discrete pins
    amp_if.dev bus,
    // address strap
    input wire logic [1:0] addr_strap,
    // supply, thermal and output monitors
    input wire logic por,
    input wire logic load_dump,
    input wire logic undervoltage_fault,
    input wire logic pump_undervoltage_fault,
    input wire logic overvoltage_fault,
    input wire logic thermal_shutdown,
    input wire logic thermal_warning,
    input wire logic clip_det,
    input wire logic tweeter_det,
    input wire logic foldback,
    // to the power stage
    output amp_pkg::amp_mode_t op_state,
    output logic fsw_500,
    output logic osc_master,
    output logic hard_mute
);
    amp_pkg::amp_dev_t r;
    amp_pkg::amp_dev_t n;
    logic [15:0] s;
    logic scl;
    logic sda;
    logic mute_n;
    logic standby_n;
    logic [1:0] strap;
    logic por_s;
    logic ld_s;
    logic [3:0] flt_s;
    logic otw_s;
    logic clip_s;
    logic tweet_s;
    logic fold_s;

    // every pin and monitor comes from another domain
    amp_sync #(
        .W(16),
        .INIT(16'hf000)
    ) u_sync (
        .clock(clock),
        .srst(srst),
        .d({bus.scl, bus.sda, bus.mute_n, bus.standby_n, addr_strap,
            por, load_dump, thermal_shutdown, overvoltage_fault,
            pump_undervoltage_fault, undervoltage_fault,
            thermal_warning, clip_det, tweeter_det, foldback}),
        .q(s)
    );
    assign scl = s[15];
    assign sda = s[14];
    assign mute_n = s[13];
    assign standby_n = s[12];
    assign strap = s[11:10];
    assign por_s = s[9];
    assign ld_s = s[8];
    assign flt_s = s[7:4];
    assign otw_s = s[3];
    assign clip_s = s[2];
    assign tweet_s = s[1];
    assign fold_s = s[0];

    function automatic logic [7:0] rd_reg(input logic [7:0] p,
        input logic [7:0] stat, input logic [7:0] ct,
        input logic [7:0] md);
        logic [7:0] v;
        v = 8'h00;
        if (p[7:2] == 6'h00) begin
            unique case (p[1:0])
                `AMP_REG_STAT: v = stat;
                `AMP_REG_CTRL: v = ct;
                `AMP_REG_MODE: v = md;
                `AMP_REG_CLR: v = 8'h00;
            endcase
        end
        return v;
    endfunction

    always_comb begin
        logic rise;
        logic fall;
        logic start;
        logic stop;
        logic live;
        logic hard;
        logic [3:0] clr;
        logic [7:0] d;
        logic [7:0] stat;
        logic [7:0] md;
        rise = scl & ~r.scl_p;
        fall = ~scl & r.scl_p;
        start = scl & r.scl_p & r.sda_p & ~sda;
        stop = scl & r.scl_p & ~r.sda_p & sda;
        // stays up in thermal standby and in the cycle that leaves it,
        // so the ack of the clearing byte is not cut short
        live = r.mode != amp_pkg::mode_stby
            || (standby_n && !por_s && !ld_s);
        hard = por_s | ld_s | r.lat[3];
        clr = 4'h0;
        d = 8'h00;
        stat = {4'h0, r.lat};
        stat[`AMP_ST_OTW] = otw_s;
        stat[`AMP_ST_CLIP] = clip_s;
        stat[`AMP_ST_FOLD] = fold_s;
        md = {6'h00, r.mode};
        n = r;
        n.scl_p = scl;
        n.sda_p = sda;

        // slave only: scl is never driven, so no stretching
        if (!live) begin
            n.st = amp_pkg::ds_idle;
            n.sda_oe = 1'b0;
        end else if (start) begin
            n.st = amp_pkg::ds_addr;
            n.bits = 4'h0;
            n.sda_oe = 1'b0;
        end else if (stop) begin
            n.st = amp_pkg::ds_idle;
            n.sda_oe = 1'b0;
        end else begin
            unique case (r.st)
                amp_pkg::ds_idle: begin
                end
                amp_pkg::ds_addr, amp_pkg::ds_rx: begin
                    if (rise) begin
                        n.sh = {r.sh[6:0], sda};
                        n.bits = r.bits + 4'h1;
                    end
                    if (fall && r.bits == 4'h8) begin
                        n.bits = 4'h0;
                        if (r.st == amp_pkg::ds_rx) begin
                            n.st = amp_pkg::ds_ack;
                            n.sda_oe = 1'b1;
                            if (r.first) begin
                                n.ptr = r.sh;
                                n.first = 1'b0;
                            end else begin
                                n.ptr = r.ptr + 8'h01;
                                if (r.ptr[7:2] == 6'h00) begin
                                    if (r.ptr[1:0] == `AMP_REG_CTRL) begin
                                        n.ctrl = r.sh;
                                    end
                                    if (r.ptr[1:0] == `AMP_REG_CLR) begin
                                        clr = r.sh[3:0];
                                    end
                                end
                            end
                        end else if (r.sh[7:1] == {`AMP_ADDR_HI, strap}) begin
                            n.st = amp_pkg::ds_ack;
                            n.sda_oe = 1'b1;
                            n.rw = r.sh[0];
                            n.first = ~r.sh[0];
                        end else begin
                            n.st = amp_pkg::ds_idle;
                        end
                    end
                end
                amp_pkg::ds_ack: begin
                    // ack is held low for the whole acknowledge clock
                    if (fall) begin
                        if (r.rw) begin
                            d = rd_reg(r.ptr, stat, r.ctrl, md);
                            n.sh = d;
                            n.sda_oe = ~d[7];
                            n.st = amp_pkg::ds_tx;
                        end else begin
                            n.sda_oe = 1'b0;
                            n.st = amp_pkg::ds_rx;
                        end
                    end
                end
                amp_pkg::ds_tx: begin
                    if (rise) begin
                        n.bits = r.bits + 4'h1;
                    end
                    if (fall) begin
                        if (r.bits == 4'h8) begin
                            n.st = amp_pkg::ds_rack;
                            n.sda_oe = 1'b0;
                            n.ptr = r.ptr + 8'h01;
                        end else begin
                            n.sh = {r.sh[6:0], 1'b0};
                            n.sda_oe = ~r.sh[6];
                        end
                    end
                end
                amp_pkg::ds_rack: begin
                    if (rise) begin
                        n.st = sda ? amp_pkg::ds_idle : amp_pkg::ds_rnext;
                    end
                end
                amp_pkg::ds_rnext: begin
                    if (fall) begin
                        d = rd_reg(r.ptr, stat, r.ctrl, md);
                        n.sh = d;
                        n.sda_oe = ~d[7];
                        n.bits = 4'h0;
                        n.st = amp_pkg::ds_tx;
                    end
                end
                default: begin
                    n.st = amp_pkg::ds_idle;
                end
            endcase
        end

        // a fault arriving with its clear stays set
        n.lat = (r.lat & ~clr) | flt_s;
        if (por_s) begin
            n.lat = 4'h0;
        end

        if (hard) begin
            n.mode = amp_pkg::mode_stby;
            n.cnt = 16'h0000;
        end else if (!standby_n) begin
            if (r.mode != amp_pkg::mode_stby
                && r.mode != amp_pkg::mode_hiz) begin
                n.mode = amp_pkg::mode_hiz;
                n.cnt = 16'h0000;
            end else if (r.mode == amp_pkg::mode_hiz) begin
                if (r.cnt == STBY_CYC - 16'h0001) begin
                    n.mode = amp_pkg::mode_stby;
                end else begin
                    n.cnt = r.cnt + 16'h0001;
                end
            end
        end else if (r.lat[2:0] != 3'h0 || !r.ctrl[`AMP_CT_RUN]) begin
            n.mode = amp_pkg::mode_hiz;
            n.cnt = 16'h0000;
        end else if (!r.ctrl[`AMP_CT_PLAY] || !mute_n) begin
            n.mode = amp_pkg::mode_mute;
        end else begin
            n.mode = amp_pkg::mode_play;
        end
        if (n.mode == amp_pkg::mode_stby
            && r.mode != amp_pkg::mode_stby) begin
            n.ctrl = `AMP_CTRL_RST;
            n.ptr = 8'h00;
        end

        n.fault_oe = (|r.lat) | por_s | ld_s;
        unique case (r.ctrl[`AMP_CT_PIN])
            `AMP_PIN_WARN: n.clip_oe = otw_s | fold_s;
            `AMP_PIN_CLIP: n.clip_oe = clip_s;
            `AMP_PIN_BOTH: n.clip_oe = otw_s | fold_s | clip_s;
            `AMP_PIN_TWEET: n.clip_oe = tweet_s;
        endcase
        n.osc_master = (strap == 2'h0);
        n.hard_mute = hard | ~mute_n;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign bus.sda_oe_d = r.sda_oe;
    assign bus.fault_oe = r.fault_oe;
    assign bus.clip_oe = r.clip_oe;
    assign op_state = r.mode;
    assign fsw_500 = r.ctrl[`AMP_CT_FSW];
    assign osc_master = r.osc_master;
    assign hard_mute = r.hard_mute;
endmodule

/* File: rtl/amp_host.sv */
// controller end: wishbone-driven byte engine for the two-wire bus
`timescale 1ns/10ps
`include "amp_params.svh"
module amp_host #(
    parameter logic [3:0] QTR = 4'(`AMP_SCL_QTR)
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // wishbone classic slave
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [3:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    // bus and discrete pins
    amp_if.host bus
);
    amp_pkg::amp_host_t r;
    amp_pkg::amp_host_t n;
    logic [2:0] s;

    amp_sync #(
        .W(3),
        .INIT(3'h7)
    ) u_sync (
        .clock(clock),
        .srst(srst),
        .d({bus.sda, bus.fault_n, bus.clip_n}),
        .q(s)
    );

    always_comb begin
        logic tick;
        logic req;
        tick = (r.q == QTR - 4'h1) && (r.st != amp_pkg::hs_idle);
        req = wb_cyc & wb_stb & ~r.ack;
        n = r;
        n.ack = req;
        if (req) begin
            n.dat = 32'h0000_0000;
            if (wb_adr == `AMP_WB_CTRL) begin
                n.dat[1:0] = {r.standby_n, r.mute_n};
            end else if (wb_adr == `AMP_WB_STAT) begin
                n.dat[`AMP_HS_BUSY] = (r.st != amp_pkg::hs_idle);
                n.dat[`AMP_HS_ACK] = ~r.rx[0];
                n.dat[`AMP_HS_FAULT] = ~s[1];
                n.dat[`AMP_HS_CLIP] = ~s[0];
                n.dat[`AMP_HS_RX] = r.rx[8:1];
            end
        end
        // writes land at the edge where the master sees ack
        if (wb_cyc && wb_stb && r.ack && wb_we) begin
            if (wb_adr == `AMP_WB_CTRL && wb_sel[0]) begin
                n.mute_n = wb_dat_w[`AMP_HC_MUTE];
                n.standby_n = wb_dat_w[`AMP_HC_STBY];
            end
            if (wb_adr == `AMP_WB_XFER && wb_sel[1:0] == 2'h3
                && r.st == amp_pkg::hs_idle) begin
                n.tx = wb_dat_w[`AMP_XF_READ]
                    ? {8'hff, wb_dat_w[`AMP_XF_NACK]}
                    : {wb_dat_w[7:0], 1'b1};
                n.stop = wb_dat_w[`AMP_XF_STOP];
                n.st = wb_dat_w[`AMP_XF_START]
                    ? amp_pkg::hs_start : amp_pkg::hs_bits;
                n.q = 4'h0;
                n.ph = 2'h0;
                n.bits = 4'h0;
            end
        end
        // quarter-bit timing sets the 400 kbit/s ceiling
        if (r.st != amp_pkg::hs_idle) begin
            n.q = tick ? 4'h0 : r.q + 4'h1;
        end
        if (tick) begin
            n.ph = r.ph + 2'h1;
            unique case (r.st)
                amp_pkg::hs_start: begin
                    unique case (r.ph)
                        2'h0: n.sda_oe = 1'b0;
                        2'h1: n.scl_oe = 1'b0;
                        2'h2: n.sda_oe = 1'b1;
                        2'h3: begin
                            n.scl_oe = 1'b1;
                            n.st = amp_pkg::hs_bits;
                        end
                    endcase
                end
                amp_pkg::hs_bits: begin
                    unique case (r.ph)
                        2'h0: n.sda_oe = ~r.tx[8];
                        2'h1: n.scl_oe = 1'b0;
                        2'h2: n.rx = {r.rx[7:0], s[2]};
                        2'h3: begin
                            n.scl_oe = 1'b1;
                            n.tx = {r.tx[7:0], 1'b1};
                            n.bits = r.bits + 4'h1;
                            if (r.bits == 4'h8) begin
                                n.sda_oe = 1'b0;
                                n.st = r.stop ? amp_pkg::hs_stop
                                    : amp_pkg::hs_idle;
                            end
                        end
                    endcase
                end
                amp_pkg::hs_stop: begin
                    unique case (r.ph)
                        2'h0: n.sda_oe = 1'b1;
                        2'h1: n.scl_oe = 1'b0;
                        2'h2: n.sda_oe = 1'b0;
                        2'h3: n.st = amp_pkg::hs_idle;
                    endcase
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign wb_dat_r = r.dat;
    assign wb_ack = r.ack;
    assign bus.scl_oe = r.scl_oe;
    assign bus.sda_oe_h = r.sda_oe;
    assign bus.mute_n = r.mute_n;
    assign bus.standby_n = r.standby_n;
endmodule

/* File: bench/amp_link_properties.sv */
// link properties watched beside the controller/amplifier interface
`timescale 1ns/10ps
module amp_link_properties #(
    parameter int STBY = 20
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // link lines
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_oe_h,
    input wire logic sda_oe_d,
    input wire logic standby_n
);
    logic [15:0] stby_q;
    logic [15:0] stby_d;
    // saturating count of cycles with the standby pin asserted
    always_comb begin
        stby_d = standby_n ? 16'h0000 : stby_q + 16'(stby_q != 16'hffff);
    end
    always_ff @(posedge clock) begin
        stby_q <= srst ? 16'h0000 : stby_d;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    AST_DEV_SDA_SCL_LOW: assert property ($changed(sda_oe_d) |-> !scl)
        else $error("device moved data while clock high");
    AST_DRIVE_AFTER_FALL: assert property ($rose(sda_oe_d) |->
        !scl && !$past(scl) && !$past(scl, 2))
        else $error("device drove data too soon after clock fall");
    AST_HOLD_HIGH: assert property ($rose(scl) && sda_oe_d |->
        sda_oe_d [*8])
        else $error("device let go of data during clock high");
    AST_ACK_TO_RISE: assert property ($rose(sda_oe_d) |->
        sda_oe_d throughout (1'b1 ##[1:30] $rose(scl)))
        else $error("device data not held up to clock rise");
    AST_QUIET_START: assert property (
        $fell(sda) && scl && $past(scl) |-> !sda_oe_d [*8])
        else $error("device drove data right after start");
    AST_QUIET_STOP: assert property (
        $rose(sda) && scl && $past(scl) |-> !sda_oe_d [*4])
        else $error("device drove data right after stop");
    AST_START_THEN_LOW: assert property ($rose(sda_oe_h) && scl |->
        ##[1:8] !scl)
        else $error("clock not pulled low after start");
    AST_STBY_RELEASE: assert property (stby_q > 16'(STBY + 16) |->
        !sda_oe_d)
        else $error("device drives data while in standby");
endmodule

/* File: bench/amp_i2c_control_fault_test.sv */
// self-checking bench joining the controller end and the amplifier end
`timescale 1ns/10ps
`include "amp_params.svh"
module amp_i2c_control_fault_test;
    logic clock = 0;
    logic srst = 1;
    logic cyc = 0;
    logic stb = 0;
    logic we = 0;
    logic ack;
    logic [3:0] adr = '0;
    logic [3:0] sel = 4'hf;
    logic [31:0] wd = '0;
    logic [31:0] rdat;
    logic [31:0] rd_w;
    logic [1:0] strap = '0;
    logic [1:0] ta = '0;
    logic [2:0] sup = '0;
    logic warn = 0;
    logic clip = 0;
    logic [4:0] ev = '0;
    logic fsw, oscm, hm;
    amp_pkg::amp_mode_t st;
    int n_mismatch = 0;
    int cmp_count = 0;
    logic [63:0] q[$];
    amp_if link();
    always #50 clock = ~clock;
    amp_host amp_host_inst (.clock(clock), .srst(srst), .wb_cyc(cyc),
        .wb_stb(stb), .wb_we(we), .wb_adr(adr), .wb_sel(sel),
        .wb_dat_w(wd), .wb_dat_r(rd_w), .wb_ack(ack), .bus(link));
    amp_dev #(.STBY_CYC(16'h0014)) amp_dev_inst (.clock(clock),
        .srst(srst), .bus(link), .addr_strap(strap), .por(ev[0]),
        .load_dump(ev[1]), .undervoltage_fault(sup[0]),
        .pump_undervoltage_fault(sup[1]), .overvoltage_fault(sup[2]),
        .thermal_shutdown(ev[2]), .thermal_warning(warn),
        .clip_det(clip), .tweeter_det(ev[3]), .foldback(ev[4]),
        .op_state(st), .fsw_500(fsw),
        .osc_master(oscm), .hard_mute(hm));
    amp_link_properties #(.STBY(20)) amp_link_properties_inst (
        .clock(clock), .srst(srst), .scl(link.scl), .sda(link.sda),
        .sda_oe_h(link.sda_oe_h), .sda_oe_d(link.sda_oe_d),
        .standby_n(link.standby_n));
    task automatic final_report;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic bad(input logic [31:0] g, input logic [31:0] e);
        n_mismatch++;
        $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    endtask
    task automatic cmp_wb(input logic [31:0] g, e, m);
        cmp_count++;
        if ((g & m) !== e) bad(g, e);
    endtask
    task automatic cmp_pin(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) bad(32'(g), 32'(e));
    endtask
    // read data is judged where ack is settled, half a cycle after it rose
    always @(negedge clock) begin
        if (ack === 1'b1 && we === 1'b0 && q.size() > 0) begin
            logic [63:0] n;
            n = q.pop_front();
            cmp_wb(rd_w, n[63:32], n[31:0]);
        end
    end
    task automatic wb(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        @(posedge clock);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wd <= d;
        // ack is taken at the rising edge where the write lands
        do @(posedge clock); while (ack !== 1'b1);
        rdat = rd_w;
        cyc <= 0;
        stb <= 0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, m);
        q.push_back({e & m, m});
        wb(0, a, 32'h0);
    endtask
    // one byte on the link, then poll until the engine is idle
    task automatic xf(input logic [11:0] f);
        wb(1, `AMP_WB_XFER, 32'(f));
        do wb(0, `AMP_WB_STAT, 32'h0);
        while (rdat[`AMP_HS_BUSY] !== 1'b0);
    endtask
    function automatic logic [7:0] ab(input logic r);
        return {`AMP_ADDR_HI, ta, r};
    endfunction
    task automatic wreg(input logic [7:0] p, input logic [7:0] v);
        xf({4'h1, ab(0)});
        xf({4'h0, p});
        xf({4'h2, v});
        rd(`AMP_WB_STAT, 32'h2, 32'h2);
    endtask
    task automatic rreg(input logic [7:0] p, e0, e1, m1);
        xf({4'h1, ab(0)});
        xf({4'h0, p});
        xf({4'h1, ab(1)});
        xf({4'h4, 8'h00});
        rd(`AMP_WB_STAT, {e0, 8'h00}, 32'h0000_ff00);
        xf({4'he, 8'h00});
        rd(`AMP_WB_STAT, {e1, 8'h00}, {m1, 8'h00});
    endtask
    initial begin
        logic [7:0] v;
        v = 8'($urandom(24));
        repeat (8) @(posedge clock);
        srst <= 0;
        wb(1, `AMP_WB_CTRL, 32'h3);
        repeat (10) @(posedge clock);
        for (int s = 0; s < 4; s++) begin
            strap <= 2'(s);
            ta = 2'(s);
            repeat (5) @(posedge clock);
            xf({4'h3, ab(0)});
            rd(`AMP_WB_STAT, 32'h2, 32'h2);
            cmp_pin(8'(oscm), 8'(s == 0));
        end
        xf({4'h3, 8'hd8});
        rd(`AMP_WB_STAT, 32'h0, 32'h2);
        v = (8'($urandom()) & 8'h1e) | 8'h01;
        wreg(8'h01, v);
        repeat (10) @(posedge clock);
        cmp_pin(8'(fsw), 8'(v[2]));
        cmp_pin(8'(st), v[1] ? 8'h03 : 8'h02);
        rreg(8'h01, v, v[1] ? 8'h03 : 8'h02, 8'hff);
        wb(1, `AMP_WB_CTRL, 32'h2);
        repeat (6) @(posedge clock);
        cmp_pin(8'(hm), 8'h01);
        cmp_pin(8'(st), 8'h02);
        wb(1, `AMP_WB_CTRL, 32'h3);
        for (int m = 0; m < 4; m++) begin
            wreg(8'h01, {3'h0, 2'(m), 3'h3});
            {warn, clip} <= 2'b10;
            repeat (6) @(posedge clock);
            rd(`AMP_WB_STAT, {28'h0, m == 0 || m == 2, 3'h0}, 32'h8);
            {warn, clip} <= 2'b01;
            repeat (6) @(posedge clock);
            rd(`AMP_WB_STAT, {28'h0, m == 1 || m == 2, 3'h0}, 32'h8);
            {warn, clip} <= 2'b00;
            ev[4:3] <= 2'b11;
            repeat (6) @(posedge clock);
            rd(`AMP_WB_STAT, {28'h0, m != 1, 3'h0}, 32'h8);
            ev[4:3] <= 2'b00;
        end
        for (int f = 0; f < 3; f++) begin
            sup <= 3'(1 << f);
            repeat (6) @(posedge clock);
            sup <= 3'h0;
            repeat (6) @(posedge clock);
            rd(`AMP_WB_STAT, 32'h4, 32'h4);
            cmp_pin(8'(st), 8'h01);
            rreg(8'h00, 8'(1 << f), 8'h1b, 8'hff);
            rd(`AMP_WB_STAT, 32'h4, 32'h4);
            wreg(8'h03, 8'(1 << f));
            repeat (6) @(posedge clock);
            rd(`AMP_WB_STAT, 32'h0, 32'h4);
        end
        // por and load dump force standby only while they last
        for (int h = 0; h < 2; h++) begin
            ev[h] <= 1'b1;
            repeat (6) @(posedge clock);
            rd(`AMP_WB_STAT, 32'h4, 32'h4);
            cmp_pin(8'(st), 8'h00);
            cmp_pin(8'(hm), 8'h01);
            ev[h] <= 1'b0;
            repeat (6) @(posedge clock);
            rd(`AMP_WB_STAT, 32'h0, 32'h4);
            cmp_pin(8'(st), 8'h01);
        end
        // thermal shutdown latches standby but keeps the bus readable
        ev[2] <= 1'b1;
        repeat (6) @(posedge clock);
        ev[2] <= 1'b0;
        repeat (6) @(posedge clock);
        cmp_pin(8'(st), 8'h00);
        rreg(8'h00, 8'h08, 8'h00, 8'hff);
        wreg(8'h03, 8'h08);
        repeat (6) @(posedge clock);
        cmp_pin(8'(st), 8'h01);
        wreg(8'h01, 8'h01);
        wb(1, `AMP_WB_CTRL, 32'h1);
        repeat (10) @(posedge clock);
        cmp_pin(8'(st), 8'h01);
        repeat (50) @(posedge clock);
        cmp_pin(8'(st), 8'h00);
        wb(1, `AMP_WB_CTRL, 32'h3);
        repeat (10) @(posedge clock);
        rreg(8'h01, 8'h00, 8'h01, 8'hff);
        final_report;
    end
    initial begin
        #9_000_000;
        n_mismatch++;
        final_report;
    end
endmodule
